/* File: design/spi_port_pkg.sv */
// Constants for the serial port status, data and shared pin block.
// Assumes an APB slave with byte addresses equal to four times a register index.
//
// Notes on behaviour
// R01: Done flag sets when the eighth serial clock cycle of a byte has ended.
// R02: Done flag clears after a status read seeing it, then a data access.
// R03: Data write during a transfer is dropped, shifter kept, collision flag set.
// R04: The collision flag never raises the interrupt request.
// R05: Collision flag clears after a status read seeing it, then a data access.
// R06: Fault flag sets while master mode is chosen and select pin is low.
// R07: Direction bit seven set disables fault detection and holds fault flag clear.
// R08: Fault flag clears after a status read seeing it, then a control write.
// R09: A mode fault forces direction bits five, six and seven to zero.
// R10: Data reads come from a read buffer; writes load the shifter directly.
// R11: Each transfer shifts eight positions, exchanging one byte each way.
// R12: Reset leaves the data register contents unchanged.
// R13: Reset clears all direction bits, so all pins are inputs except those an async transmitter claims, bit three or one.
// R14: Port read gives pin level for inputs, driver value for outputs.
// R15: Port writes fill a latch driving only general outputs, never function pins.
// R16: Direction bit zero means input, one means output, unless a function overrides.
// R17: Async receiver in two-wire use forces its pin, bit two or zero, to input.
// R18: Async transmitter in two-wire use forces its pin, bit three or one, to output.
// R19: Enabled serial inputs on pins six to four ignore direction; outputs need it.
// R20: Slave mode: pin seven is select input; master: bit seven picks its role.
// R21: With interrupt enable set, done or fault flag requests an interrupt.
// R22: Software writes to the status register are ignored.
// R23: A flag set coinciding with the last step of its clear leaves it set.

package spi_port_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 10;
  localparam logic [7:0]  IDX_CTRL   = 8'hd0;
  localparam logic [7:0]  IDX_BAUD   = 8'hd2;
  localparam logic [7:0]  IDX_STATUS = 8'hd3;
  localparam logic [7:0]  IDX_DATA   = 8'hd5;
  localparam logic [7:0]  IDX_PORT   = 8'hd6;
  localparam logic [7:0]  IDX_DIR    = 8'hd7;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CR_IRQ_EN    = 7;
  localparam int unsigned CR_ENABLE    = 6;
  localparam int unsigned CR_MASTER    = 4;
  localparam int unsigned CR_CPOL      = 3;
  localparam int unsigned CR_CPHA      = 2;
  localparam int unsigned CR_SEL_OUT   = 1;
  localparam int unsigned CR_LSB_FIRST = 0;
  localparam logic [7:0]  CTRL_FAULT_HIDE = 8'h50;

  // Status register fields
  localparam int unsigned ST_DONE  = 7;
  localparam int unsigned ST_COLL  = 6;
  localparam int unsigned ST_FAULT = 4;

  // ----------------------------------------------------------------
  // Pin positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PIN_RX0  = 0;
  localparam int unsigned PIN_TX0  = 1;
  localparam int unsigned PIN_RX1  = 2;
  localparam int unsigned PIN_TX1  = 3;
  localparam int unsigned PIN_MISO = 4;
  localparam int unsigned PIN_MOSI = 5;
  localparam int unsigned PIN_SCK  = 6;
  localparam int unsigned PIN_SEL  = 7;
  localparam logic [7:0]  DIR_FAULT_KEEP = 8'h1f;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  BAUD_RST = 8'h00;
  localparam logic [7:0]  DIR_RST  = 8'h00;
  localparam logic [7:0]  PORT_RST = 8'h00;

  // Serial clock edges in one byte and rate field width
  localparam int unsigned RATE_W      = 3;
  localparam logic [4:0]  LAST_EDGE   = 5'h0f;

endpackage : spi_port_pkg

/* File: design/sync_two_ff.sv */
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no bus coherency is given.
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : sync_two_ff

/* File: design/serial_shifter.sv */
// Byte shift engine: master clock generation or slave edge following.
// Assumes serial clock and select inputs are already synchronised.
`timescale 1ns/1ps
module serial_shifter import spi_port_pkg::*; #(
  parameter int unsigned RW = RATE_W
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  input  wire logic          i_master,
  input  wire logic          i_enable,
  input  wire logic          i_cpha,
  input  wire logic          i_lsbf,
  input  wire logic [RW-1:0] i_rate,
  input  wire logic          i_load,
  input  wire logic [7:0]    i_load_data,
  input  wire logic          i_sck,
  input  wire logic          i_sel_n,
  input  wire logic          i_sdi,
  output logic               o_sck_level,
  output logic               o_sdo,
  output logic               o_busy,
  output logic               o_done,
  output logic [7:0]         o_rx_data
);
  logic [7:0] tx_q;
  logic [8:0] div_q;
  logic [4:0] edges_q;
  logic       run_q;
  logic       sck_prev_q;

  // Edge selection and bit position
  wire [8:0] half     = 9'h001 << i_rate;
  wire       tick     = run_q & (div_q == half - 9'h001);
  wire       sl_edge  = ~i_sel_n & (i_sck != sck_prev_q);
  wire       edge_hit = i_enable & (i_master ? tick : sl_edge);
  wire       sample   = edge_hit & (edges_q[0] == i_cpha);
  wire       last     = edge_hit & (edges_q == LAST_EDGE); // R01
  wire [4:0] adj      = edges_q - {4'h0, i_cpha};
  wire [2:0] pos      = i_lsbf ? adj[3:1] : 3'h7 - adj[3:1];
  wire       abort    = ~i_enable | (~i_master & i_sel_n);

  assign o_busy = run_q | (edges_q != 5'h00);
  assign o_sdo  = tx_q[pos];

  // Data path has no reset so contents survive it
  always_ff @(posedge i_clock) begin
    if (o_done) tx_q <= o_rx_data; // R11
    if (i_load) tx_q <= i_load_data; // R10
    if (sample) o_rx_data[pos] <= i_sdi; // R11
  end

  // Clock divider, edge counter and serial clock level
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      div_q <= 9'h000;
      edges_q <= 5'h00;
      o_sck_level <= 1'b0;
      sck_prev_q <= 1'b0;
      o_done <= 1'b0;
    end else begin
      sck_prev_q <= i_sck;
      o_done <= last;
      div_q <= (run_q & ~tick) ? div_q + 9'h001 : 9'h000;
      if (abort) begin
        run_q <= 1'b0;
        edges_q <= 5'h00;
        o_sck_level <= 1'b0;
      end else if (i_load & i_master) begin
        run_q <= 1'b1;
      end else if (edge_hit) begin
        edges_q <= last ? 5'h00 : edges_q + 5'h01;
        o_sck_level <= ~o_sck_level;
        if (last) run_q <= 1'b0;
      end
    end
  end
endmodule : serial_shifter

/* File: design/spi_status_data_port.sv */
// Serial port status flags, data register and shared port pin control.
// Assumes an APB master on i_clock and pins that arrive asynchronously.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module spi_status_data_port import spi_port_pkg::*; (
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic [7:0]        i_pin,
  output logic      [7:0]        o_pin,
  output logic      [7:0]        o_pin_oe,
  input  wire logic [1:0]        i_async_rx_on,
  input  wire logic [1:0]        i_async_tx_on,
  input  wire logic [1:0]        i_async_txd,
  output logic      [1:0]        o_async_rxd,
  output logic                   o_serial_irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Release is delayed two edges; assertion is immediate
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_s;

  sync_two_ff #(
    .WIDTH (8)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .i_async (i_pin),
    .o_sync  (pin_s)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] baud_q;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] port_q;
  logic [7:0] rbuf_q;
  logic       done_flag_q;
  logic       coll_flag_q;
  logic       fault_flag_q;
  logic       arm_done_q;
  logic       arm_coll_q;
  logic       arm_fault_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [7:0] idx        = i_paddr[ADDR_W-1:2];
  wire       setup      = i_psel & ~i_penable;
  wire       access     = i_psel & i_penable;
  wire       hit_ctrl   = (idx == IDX_CTRL);
  wire       hit_baud   = (idx == IDX_BAUD);
  wire       hit_status = (idx == IDX_STATUS);
  wire       hit_data   = (idx == IDX_DATA);
  wire       hit_port   = (idx == IDX_PORT);
  wire       hit_dir    = (idx == IDX_DIR);
  wire       hit_any    = hit_ctrl | hit_baud | hit_status
                        | hit_data | hit_port | hit_dir;
  wire       wr         = access & i_pwrite;
  wire       rd         = access & ~i_pwrite;
  wire [7:0] wdata      = i_pwdata[7:0];

  // Zero wait states; unmapped addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~hit_any;

  // ----------------------------------------------------------------
  // Shifter hookup
  // ----------------------------------------------------------------
  logic       sck_level;
  logic       sdo;
  logic       busy;
  logic       xfer_done;
  logic [7:0] rx_data;

  // Fault hides the enable and master bits from the logic
  wire eff_master = ctrl_q[CR_MASTER] & ~fault_flag_q;
  wire eff_enable = ctrl_q[CR_ENABLE] & ~fault_flag_q;
  wire sel_in_n   = eff_master | pin_s[PIN_SEL]; // R20
  wire sdi        = eff_master ? pin_s[PIN_MISO] : pin_s[PIN_MOSI];

  // A write while shifting is dropped, not queued
  wire data_acc = access & hit_data;
  wire data_ld  = wr & hit_data & ~busy; // R03 R10
  wire coll_evt = wr & hit_data & busy; // R03

  serial_shifter #(
    .RW (RATE_W)
  ) u_shifter (
    .i_clock     (i_clock),
    .i_rst_n     (rst_n),
    .i_master    (eff_master),
    .i_enable    (eff_enable),
    .i_cpha      (ctrl_q[CR_CPHA]),
    .i_lsbf      (ctrl_q[CR_LSB_FIRST]),
    .i_rate      (baud_q[RATE_W-1:0]),
    .i_load      (data_ld),
    .i_load_data (wdata),
    .i_sck       (pin_s[PIN_SCK]),
    .i_sel_n     (sel_in_n),
    .i_sdi       (sdi),
    .o_sck_level (sck_level),
    .o_sdo       (sdo),
    .o_busy      (busy),
    .o_done      (xfer_done),
    .o_rx_data   (rx_data)
  );

  // ----------------------------------------------------------------
  // Mode fault
  // ----------------------------------------------------------------
  // Detection only while master mode is chosen and direction bit seven is clear
  wire fault_evt = ctrl_q[CR_MASTER] & ~dir_q[PIN_SEL]
                 & ~pin_s[PIN_SEL]; // R06 R07

  // Fault wins over a same-cycle direction write
  wire [7:0] dir_wr = (wr & hit_dir) ? wdata : dir_q;
  assign dir_d = fault_evt ? (dir_wr & DIR_FAULT_KEEP) : dir_wr; // R09

  // ----------------------------------------------------------------
  // Flag clear sequences
  // ----------------------------------------------------------------
  wire st_rd   = rd & hit_status;
  wire ctrl_wr = wr & hit_ctrl;

  // Arming remembers what the status read actually returned
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      arm_done_q <= 1'b0;
      arm_coll_q <= 1'b0;
      arm_fault_q <= 1'b0;
    end else if (st_rd) begin
      arm_done_q <= o_prdata[ST_DONE];
      arm_coll_q <= o_prdata[ST_COLL];
      arm_fault_q <= o_prdata[ST_FAULT];
    end else begin
      if (data_acc) arm_done_q <= 1'b0;
      if (data_acc) arm_coll_q <= 1'b0;
      if (ctrl_wr) arm_fault_q <= 1'b0;
    end
  end

  // Set terms come first so a coincident clear loses
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      done_flag_q <= 1'b0;
      coll_flag_q <= 1'b0;
      fault_flag_q <= 1'b0;
    end else begin
      if (xfer_done) done_flag_q <= 1'b1; // R01 R23
      else if (data_acc & arm_done_q) done_flag_q <= 1'b0; // R02
      if (coll_evt) coll_flag_q <= 1'b1; // R03 R23
      else if (data_acc & arm_coll_q) coll_flag_q <= 1'b0; // R05
      if (fault_evt) fault_flag_q <= 1'b1; // R06 R23
      else if (dir_q[PIN_SEL]) fault_flag_q <= 1'b0; // R07
      else if (ctrl_wr & arm_fault_q) fault_flag_q <= 1'b0; // R08
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Status has no write path at all
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      dir_q <= DIR_RST; // R13
      port_q <= PORT_RST;
    end else begin
      if (ctrl_wr) ctrl_q <= wdata;
      if (wr & hit_baud) baud_q <= wdata;
      if (wr & hit_port) port_q <= wdata; // R15
      dir_q <= dir_d; // R09 R16
    end
  end // R22

  // Read buffer keeps its byte across reset
  always_ff @(posedge i_clock) begin
    if (xfer_done) rbuf_q <= rx_data; // R10 R12
  end

  // ----------------------------------------------------------------
  // Pin function overrides
  // ----------------------------------------------------------------
  logic [7:0] own;
  logic [7:0] f_oe;
  logic [7:0] f_out;

  // Serial units claim pins; unclaimed pins stay general
  always_comb begin
    own = 8'h00;
    f_oe = 8'h00;
    f_out = port_q;
    own[PIN_RX0] = i_async_rx_on[0]; // R17
    own[PIN_RX1] = i_async_rx_on[1]; // R17
    own[PIN_TX0] = i_async_tx_on[0]; // R18
    own[PIN_TX1] = i_async_tx_on[1]; // R18
    f_oe[PIN_TX0] = 1'b1; // R18
    f_oe[PIN_TX1] = 1'b1; // R18
    f_out[PIN_TX0] = i_async_txd[0];
    f_out[PIN_TX1] = i_async_txd[1];
    if (eff_enable) begin
      own[PIN_MISO] = 1'b1;
      own[PIN_MOSI] = 1'b1;
      own[PIN_SCK] = 1'b1;
      // Inputs ignore direction; outputs still need it
      f_oe[PIN_MISO] = ~eff_master & dir_q[PIN_MISO]
                     & ~pin_s[PIN_SEL]; // R19
      f_oe[PIN_MOSI] = eff_master & dir_q[PIN_MOSI]; // R19
      f_oe[PIN_SCK] = eff_master & dir_q[PIN_SCK]; // R19
      f_out[PIN_MISO] = sdo;
      f_out[PIN_MOSI] = sdo;
      f_out[PIN_SCK] = sck_level ^ ctrl_q[CR_CPOL];
      // Slave: select input; master: direction bit picks role
      if (!eff_master || !dir_q[PIN_SEL]) begin
        own[PIN_SEL] = 1'b1; // R20
      end else if (ctrl_q[CR_SEL_OUT]) begin
        own[PIN_SEL] = 1'b1; // R20
        f_oe[PIN_SEL] = 1'b1;
        f_out[PIN_SEL] = ~busy;
      end
    end
  end

  // Direction register governs unclaimed pins and also gates the claimed outputs on pins four to seven, but not the async transmit pins
  assign o_pin_oe    = (own & f_oe) | (~own & dir_q); // R16
  assign o_pin       = (own & f_out) | (~own & port_q); // R15
  assign o_async_rxd = {pin_s[PIN_RX1], pin_s[PIN_RX0]};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] status_v = {done_flag_q, coll_flag_q, 1'b0,
                         fault_flag_q, 4'h0};
  wire [7:0] ctrl_v   = fault_flag_q ? (ctrl_q & ~CTRL_FAULT_HIDE) : ctrl_q;
  wire [7:0] port_v   = (o_pin_oe & o_pin) | (~o_pin_oe & pin_s); // R14
  wire [7:0] rd_mux   = ({8{hit_ctrl}} & ctrl_v)
                      | ({8{hit_baud}} & baud_q)
                      | ({8{hit_status}} & status_v)
                      | ({8{hit_data}} & rbuf_q) // R10
                      | ({8{hit_port}} & port_v)
                      | ({8{hit_dir}} & dir_q);

  // Captured in setup so the value seen is the value armed on
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup & ~i_pwrite) begin
      o_prdata <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Collision is deliberately left out of the request
  assign o_serial_irq = ctrl_q[CR_IRQ_EN]
                      & (done_flag_q | fault_flag_q); // R21 R04

endmodule : spi_status_data_port

/* File: dv/spi_port_assertions.sv */
// Checker for the serial port block: pin direction, pin value and irq relations.
// Assumes it is bound to spi_status_data_port and sees only its ports.
`timescale 1ns/1ps
module spi_port_assertions import spi_port_pkg::*; (
  input wire logic              i_clock,
  input wire logic              i_nrst,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic [7:0]        i_pin,
  input wire logic [7:0]        o_pin,
  input wire logic [7:0]        o_pin_oe,
  input wire logic [1:0]        i_async_rx_on,
  input wire logic [1:0]        i_async_tx_on,
  input wire logic [1:0]        i_async_txd,
  input wire logic              o_serial_irq
);
  // ------------------------------------------------------------
  // Control shadow
  // ------------------------------------------------------------
  logic sel_low;
  logic master_q;
  logic irq_en_q;
  logic en_q;
  assign sel_low = master_q & ~i_pin[PIN_SEL] & ~o_pin_oe[PIN_SEL];
  // Only software writes move it, so a fault hiding the master bit is not copied
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      master_q <= 1'b0;
      irq_en_q <= 1'b0;
      en_q <= 1'b0;
    end else if (i_psel && i_penable && i_pwrite && i_paddr[9:2] == IDX_CTRL) begin
      master_q <= i_pwdata[CR_MASTER];
      irq_en_q <= i_pwdata[CR_IRQ_EN];
      en_q <= i_pwdata[CR_ENABLE];
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  reset_inputs_a: assert property (disable iff (1'b0) !i_nrst |-> o_pin_oe == 8'h00)
    else $error("pins driven during reset");
  rx_pin_input_a: assert property (((i_async_rx_on & $past(i_async_rx_on))
    & {o_pin_oe[PIN_RX1], o_pin_oe[PIN_RX0]}) == 2'b00) else $error("receive pin driven");
  tx_pin_output_a: assert property (({o_pin_oe[PIN_TX1], o_pin_oe[PIN_TX0]}
    | ~(i_async_tx_on & $past(i_async_tx_on))) == 2'b11) else $error("transmit pin not driven");
  tx_value_a: assert property (i_async_tx_on[0] && $past(i_async_tx_on[0])
    && $stable(i_async_txd[0]) |-> o_pin[PIN_TX0] == i_async_txd[0]) else $error("tx pin value");
  fault_dir_clear_a: assert property (sel_low [*6] |-> o_pin_oe[7:5] == 3'b000)
    else $error("fault left serial pins driven");
  fault_irq_a: assert property ((irq_en_q && sel_low) [*8] |-> o_serial_irq)
    else $error("fault raised no interrupt");
  irq_masked_a: assert property (!irq_en_q [*3] |-> !o_serial_irq)
    else $error("interrupt while disabled");
  slave_sel_in_a: assert property ((en_q && !master_q) [*3] |-> !o_pin_oe[PIN_SEL])
    else $error("select pin driven in slave mode");
endmodule : spi_port_assertions

bind spi_status_data_port spi_port_assertions i_spi_port_assertions (
  .i_clock, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_pin, .o_pin, .o_pin_oe, .i_async_rx_on, .i_async_tx_on, .i_async_txd,
  .o_serial_irq
);

/* File: dv/spi_slave_model.sv */
// Behavioural external slave: clock idles low, sample on rising edge, msb first.
// Assumes the block is master and drives clock, data out and select.
`timescale 1ns/1ps
module spi_slave_model (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_sel_n,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_miso,
  output logic [7:0]      o_rx_byte
);
  logic [7:0] shift_q;
  initial begin
    shift_q   = 8'h00;
    o_miso    = 1'b0;
    o_rx_byte = 8'h00;
  end
  // Select low loads the reply; first bit is out before any edge
  always @(negedge i_sel_n) begin
    shift_q = i_tx_byte;
    o_miso  = i_tx_byte[7];
  end
  // Eight sampling and eight shifting edges exchange one byte
  always @(posedge i_sck) if (!i_sel_n) o_rx_byte = {o_rx_byte[6:0], i_mosi};
  always @(negedge i_sck) if (!i_sel_n) begin
    shift_q = {shift_q[6:0], 1'b0};
    o_miso  = shift_q[7];
  end
  // Released line shows the inverse, not a stale level
  always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule : spi_slave_model

/* File: dv/spi_status_data_port_tb.sv */
// Self-checking bench for the serial port status, data and shared pin block.
// Assumes the package constants, the checker bind and the slave model.
`timescale 1ns/1ps
module spi_status_data_port_tb import spi_port_pkg::*;;
  logic              i_clock;
  logic              i_nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [7:0]        pin_w;
  logic [7:0]        pin_o;
  logic [7:0]        pin_oe;
  logic [7:0]        ext;
  logic [7:0]        drv;
  logic [1:0]        rx_on;
  logic [1:0]        tx_on;
  logic [1:0]        txd;
  logic [1:0]        rxd;
  logic              irq;
  logic              miso;
  logic [7:0]        slv_tx;
  logic [7:0]        slv_rx;
  logic [31:0]       seed;
  logic [31:0]       rv;
  logic              ev;
  int                fail_count;
  int                checked;

  // Wire level: driver when enabled, else the outside party
  assign drv   = {ext[7:5], miso, ext[3:0]};
  assign pin_w = (pin_oe & pin_o) | (~pin_oe & drv);

  spi_status_data_port i_spi_status_data_port (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pin(pin_w), .o_pin(pin_o),
    .o_pin_oe(pin_oe), .i_async_rx_on(rx_on), .i_async_tx_on(tx_on),
    .i_async_txd(txd), .o_async_rxd(rxd), .o_serial_irq(irq)
  );
  spi_slave_model i_spi_slave_model (
    .i_sck(pin_w[PIN_SCK]), .i_mosi(pin_w[PIN_MOSI]), .i_sel_n(pin_w[PIN_SEL]),
    .i_tx_byte(slv_tx), .o_miso(miso), .o_rx_byte(slv_rx)
  );

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] port_exp(input logic [7:0] lat, input logic [7:0] dir,
                                          input logic [7:0] lvl);
    return (lat & dir) | (lvl & ~dir);
  endfunction : port_exp

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic give_up();
    fail_count++;
    $display("FAIL %0t wait ran out", $time);
    end_of_test();
  endtask : give_up

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge i_clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) give_up();
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rv, {24'h0, exp});
  endtask : rdc

  task automatic do_reset();
    i_nrst <= 1'b0;
    tick(2);
    i_nrst <= 1'b1;
    tick(3);
  endtask : do_reset

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_on, tx_on, txd, slv_tx} = '0;
    ext        = 8'hff;
    i_nrst     = 1'b1;
    seed       = 32'ha6059012;
    fail_count = 0;
    checked    = 0;
    do_reset();
    chk(pin_oe, 8'h00);
    rdc(IDX_DIR, 8'h00);
    rdc(IDX_STATUS, 8'h00);
    apb(1'b0, 8'hd4, 8'h00);
    chk({ev, rv}, 33'h100000000);
    $display("test reset and map finished");
    // Random latch, direction and pin levels with the serial unit idle
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      ext <= {1'b1, seed[22:16]};
      wr(IDX_PORT, seed[15:8]);
      wr(IDX_DIR, {1'b0, seed[6:0]});
      tick(3);
      chk(pin_oe, {1'b0, seed[6:0]});
      chk(pin_o & pin_oe, seed[15:8] & {1'b0, seed[6:0]});
      rdc(IDX_PORT, port_exp(seed[15:8], {1'b0, seed[6:0]}, drv));
    end
    $display("test general pins finished");
    // Two-wire async units override direction and latch
    seed = lfsr(seed);
    rx_on <= 2'b11;
    tx_on <= 2'b11;
    txd   <= seed[1:0];
    wr(IDX_PORT, {4'h0, ~seed[1], 1'b0, ~seed[0], 1'b0});
    wr(IDX_DIR, 8'h05);
    tick(4);
    chk(pin_oe & 8'h0f, 8'h0a);
    chk({pin_o[PIN_TX1], pin_o[PIN_TX0]}, seed[1:0]);
    chk(rxd, {drv[PIN_RX1], drv[PIN_RX0]});
    rx_on <= 2'b00;
    tx_on <= 2'b00;
    $display("test async pins finished");
    // Master exchange with a second write landing mid-transfer
    seed = lfsr(seed);
    slv_tx <= seed[7:0];
    ext    <= 8'hff;
    wr(IDX_CTRL, 8'hd2);
    wr(IDX_DIR, 8'he0);
    wr(IDX_BAUD, 8'h02);
    wr(IDX_DATA, seed[15:8]);
    wr(IDX_DATA, ~seed[15:8]);
    tick(1);
    chk(irq, 1'b0);
    for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge i_clock);
    if (irq !== 1'b1) give_up();
    rdc(IDX_STATUS, 8'hc0);
    rdc(IDX_DATA, seed[7:0]);
    chk(slv_rx, seed[15:8]);
    rdc(IDX_STATUS, 8'h00);
    chk(irq, 1'b0);
    $display("test transfer finished");
    // Reset after the finished transfer keeps the received byte
    do_reset();
    rdc(IDX_DATA, seed[7:0]);
    rdc(IDX_DIR, 8'h00);
    $display("test second reset finished");
    // Select pin low in master mode: first as own output, then as fault input
    wr(IDX_CTRL, 8'h90);
    wr(IDX_PORT, 8'h00);
    wr(IDX_DIR, 8'h80);
    tick(8);
    rdc(IDX_STATUS, 8'h00);
    wr(IDX_DIR, 8'h60);
    ext <= 8'h7f;
    tick(8);
    rdc(IDX_STATUS, 8'h10);
    chk(irq, 1'b1);
    rdc(IDX_DIR, 8'h00);
    wr(IDX_STATUS, 8'h00);
    rdc(IDX_STATUS, 8'h10);
    ext <= 8'hff;
    tick(4);
    wr(IDX_CTRL, 8'h00);
    rdc(IDX_STATUS, 8'h00);
    $display("test mode fault finished");
    end_of_test();
  end
endmodule : spi_status_data_port_tb
